// ### swc_coupler_dev.sv
// coupler end: id code, ROM layer, function commands, branch switches
`timescale 1ns/1ps
`include "swc_regs.svh"
module swc_coupler_dev
  import swc_pkg::*;
#(
  parameter logic [7:0] TYPE_CODE = 8'h3C, // arbitrary value
  parameter logic [47:0] SERIAL = 48'h0000_0000_0001, // arbitrary value
  parameter int RST_MIN_CYC = `SWC_CYC(`SWC_RST_MIN_NS),
  parameter int BRST_CYC = `SWC_CYC(`SWC_RST_NS),
  parameter int PLOW_CYC = `SWC_CYC(`SWC_PLOW_NS),
  parameter int PWAIT_CYC = `SWC_CYC(`SWC_PWAIT_NS),
  parameter int SAMP_CYC = `SWC_CYC(`SWC_DSAMP_NS)
) (
  input wire logic clk,
  input wire logic nrst,
  swc_link_if.dev link,
  input wire logic mainIn,
  input wire logic auxIn,
  output logic mainOe,
  output logic auxOe,
  output logic mainOn,
  output logic auxOn,
  output logic ctrlOe
);
  localparam logic [15:0] RST_C = 16'(RST_MIN_CYC);
  localparam logic [15:0] BR_C = 16'(BRST_CYC - 1);
  localparam logic [15:0] PW_C = 16'(PWAIT_CYC);
  localparam logic [15:0] PE_C = 16'(PWAIT_CYC + PLOW_CYC);
  localparam logic [15:0] SAMP_C = 16'(SAMP_CYC);
  localparam logic [63:0] ROM_ID = {swc_rom_crc({SERIAL, TYPE_CODE}), SERIAL, TYPE_CODE};

  if (RST_MIN_CYC < 1 || BRST_CYC < 2 || PLOW_CYC < 1 || RST_MIN_CYC > `SWC_CNT_MAX ||
      PWAIT_CYC < 1 || SAMP_CYC < 2 || SAMP_CYC > `SWC_CNT_MAX ||
      BRST_CYC > `SWC_CNT_MAX || PWAIT_CYC + PLOW_CYC > `SWC_CNT_MAX) begin : g_chk
    $error("swc_coupler_dev: timing count out of range");
  end

  // link slot timing
  logic dqS1_ff, dqS2_ff, dqPrev_ff, drive0_ff, devOe_ff;
  logic nxt_dqS1, nxt_dqS2, nxt_dqPrev, nxt_drive0, nxt_devOe;
  logic [15:0] lowCnt_ff, slotCnt_ff, presCnt_ff;
  logic [15:0] nxt_lowCnt, nxt_slotCnt, nxt_presCnt;
  logic falling, rising, rstEvt, bitEvt, rxBit, txEn, txBit;

  always_comb begin
    nxt_dqS1 = link.dq;
    nxt_dqS2 = dqS1_ff;
    nxt_dqPrev = dqS2_ff;
    falling = dqPrev_ff & ~dqS2_ff;
    rising = ~dqPrev_ff & dqS2_ff;
    rstEvt = rising && (lowCnt_ff >= RST_C);
    bitEvt = (slotCnt_ff == SAMP_C);
    rxBit = dqS2_ff;
    if (dqS2_ff) begin
      nxt_lowCnt = 16'h0000;
    end else if (lowCnt_ff == 16'hFFFF) begin
      nxt_lowCnt = lowCnt_ff;
    end else begin
      nxt_lowCnt = lowCnt_ff + 16'h0001;
    end
    if (rstEvt) begin
      nxt_presCnt = 16'h0001;
    end else if (presCnt_ff == PE_C) begin
      nxt_presCnt = 16'h0000;
    end else if (presCnt_ff != 16'h0000) begin
      nxt_presCnt = presCnt_ff + 16'h0001;
    end else begin
      nxt_presCnt = presCnt_ff;
    end
    if (falling && presCnt_ff == 16'h0000 && slotCnt_ff == 16'h0000) begin
      nxt_slotCnt = 16'h0001;
    end else if (bitEvt) begin
      nxt_slotCnt = 16'h0000;
    end else if (slotCnt_ff != 16'h0000) begin
      nxt_slotCnt = slotCnt_ff + 16'h0001;
    end else begin
      nxt_slotCnt = slotCnt_ff;
    end
    nxt_drive0 = falling ? (txEn & ~txBit) : drive0_ff;
    nxt_devOe = (presCnt_ff >= PW_C && presCnt_ff < PE_C) ||
      (slotCnt_ff != 16'h0000 && drive0_ff);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dqS1_ff <= 1'b1;
      dqS2_ff <= 1'b1;
      dqPrev_ff <= 1'b1;
      drive0_ff <= 1'b0;
      devOe_ff <= 1'b0;
      lowCnt_ff <= 16'h0000;
      slotCnt_ff <= 16'h0000;
      presCnt_ff <= 16'h0000;
    end else begin
      dqS1_ff <= nxt_dqS1;
      dqS2_ff <= nxt_dqS2;
      dqPrev_ff <= nxt_dqPrev;
      drive0_ff <= nxt_drive0;
      devOe_ff <= nxt_devOe;
      lowCnt_ff <= nxt_lowCnt;
      slotCnt_ff <= nxt_slotCnt;
      presCnt_ff <= nxt_presCnt;
    end
  end

  assign link.devOe = devOe_ff;

  // protocol and branch control
  swc_dev_state_t state_ff, nxt_state;
  logic [15:0] shift_ff, nxt_shift, brCnt_ff, nxt_brCnt;
  logic [6:0] bitCnt_ff, nxt_bitCnt;
  logic [3:0] lastBit_ff, nxt_lastBit;
  logic mainOn_ff, auxOn_ff, mode_ff, sel_ff, data_ff, evMain_ff, evAux_ff, brAux_ff;
  logic nxt_mainOn, nxt_auxOn, nxt_mode, nxt_sel, nxt_data, nxt_evMain, nxt_evAux, nxt_brAux;
  logic mainOe_ff, auxOe_ff, ctrlOe_ff, nxt_mainOe, nxt_auxOe, nxt_ctrlOe;
  logic mainS1_ff, mainS2_ff, mainPrev_ff, auxS1_ff, auxS2_ff, auxPrev_ff;
  logic clrEv, romBit;
  logic [7:0] cmdIn, info;

  always_comb begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_lastBit = lastBit_ff;
    nxt_brCnt = brCnt_ff;
    nxt_brAux = brAux_ff;
    nxt_mainOn = mainOn_ff;
    nxt_auxOn = auxOn_ff;
    nxt_mode = mode_ff;
    nxt_sel = sel_ff;
    nxt_data = data_ff;
    nxt_mainOe = mainOe_ff;
    nxt_auxOe = auxOe_ff;
    clrEv = 1'b0;
    info = 8'h00;
    txEn = 1'b0;
    txBit = 1'b1;
    cmdIn = {rxBit, shift_ff[7:1]};
    romBit = ROM_ID[bitCnt_ff[5:0]];
    case (state_ff)
      SWC_S_ROMCMD, SWC_S_FUNC, SWC_S_STATCTL: begin
        if (bitEvt) begin
          nxt_shift = {8'h00, cmdIn};
          nxt_bitCnt = bitCnt_ff + 7'h01;
          if (bitCnt_ff == 7'h07) begin
            nxt_bitCnt = 7'h00;
            nxt_lastBit = 4'h7;
            nxt_state = SWC_S_DONE;
            if (state_ff == SWC_S_ROMCMD) begin
              case (cmdIn)
                `SWC_ROM_READ: nxt_state = SWC_S_READROM;
                `SWC_ROM_MATCH: nxt_state = SWC_S_MATCH;
                `SWC_ROM_SEARCH: nxt_state = SWC_S_SRCH_ID;
                `SWC_ROM_SKIP: nxt_state = SWC_S_FUNC;
                `SWC_ROM_CSRCH: begin
                  if (evMain_ff || evAux_ff) begin
                    nxt_state = SWC_S_SRCH_ID;
                  end
                end
                default: nxt_state = SWC_S_DONE;
              endcase
            end else if (state_ff == SWC_S_FUNC) begin
              case (cmdIn)
                `SWC_FN_STATUS: nxt_state = SWC_S_STATCTL;
                `SWC_FN_ALLOFF: begin
                  nxt_mainOn = 1'b0;
                  nxt_auxOn = 1'b0;
                  clrEv = 1'b1;
                  nxt_state = SWC_S_TX;
                end
                `SWC_FN_DIRMAIN: begin
                  nxt_mainOn = 1'b1;
                  nxt_auxOn = 1'b0;
                  nxt_state = SWC_S_TX;
                end
                `SWC_FN_SMARTMAIN, `SWC_FN_SMARTAUX: begin
                  nxt_mainOn = 1'b0;
                  nxt_auxOn = 1'b0;
                  nxt_brAux = (cmdIn == `SWC_FN_SMARTAUX);
                  nxt_mainOe = (cmdIn != `SWC_FN_SMARTAUX);
                  nxt_auxOe = (cmdIn == `SWC_FN_SMARTAUX);
                  nxt_brCnt = 16'h0000;
                  nxt_state = SWC_S_BRLOW;
                end
                default: nxt_state = SWC_S_DONE;
              endcase
            end else begin
              if (cmdIn[`SWC_SC_WRHI:`SWC_SC_WRLO] == 2'b00) begin
                nxt_mode = cmdIn[`SWC_SC_MODE];
                nxt_sel = cmdIn[`SWC_SC_SEL];
                nxt_data = cmdIn[`SWC_SC_DATA];
              end
              info = {nxt_mode, nxt_mode ? nxt_data : nxt_sel, evAux_ff, evMain_ff,
                auxS2_ff, ~auxOn_ff, mainS2_ff, ~mainOn_ff};
              nxt_shift = {info, info};
              nxt_lastBit = 4'hF;
              nxt_state = SWC_S_TX;
            end
          end
        end
      end
      SWC_S_READROM, SWC_S_MATCH: begin
        txEn = (state_ff == SWC_S_READROM);
        txBit = romBit;
        if (bitEvt) begin
          nxt_bitCnt = bitCnt_ff + 7'h01;
          if (state_ff == SWC_S_MATCH && rxBit != romBit) begin
            nxt_state = SWC_S_DONE;
          end else if (bitCnt_ff == 7'd63) begin
            nxt_bitCnt = 7'h00;
            nxt_state = SWC_S_FUNC;
          end
        end
      end
      SWC_S_SRCH_ID, SWC_S_SRCH_CMP: begin
        txEn = 1'b1;
        txBit = (state_ff == SWC_S_SRCH_ID) ? romBit : ~romBit;
        if (bitEvt) begin
          nxt_state = (state_ff == SWC_S_SRCH_ID) ? SWC_S_SRCH_CMP : SWC_S_SRCH_DIR;
        end
      end
      SWC_S_SRCH_DIR: begin
        if (bitEvt) begin
          nxt_bitCnt = bitCnt_ff + 7'h01;
          nxt_state = SWC_S_SRCH_ID;
          if (rxBit != romBit) begin
            nxt_state = SWC_S_DONE;
          end else if (bitCnt_ff == 7'd63) begin
            nxt_bitCnt = 7'h00;
            nxt_state = SWC_S_FUNC;
          end
        end
      end
      SWC_S_BRLOW, SWC_S_BRWAIT: begin
        nxt_brCnt = brCnt_ff + 16'h0001;
        if (brCnt_ff == BR_C) begin
          nxt_brCnt = 16'h0000;
          nxt_mainOe = 1'b0;
          nxt_auxOe = 1'b0;
          nxt_state = SWC_S_BRWAIT;
          if (state_ff == SWC_S_BRWAIT) begin
            nxt_mainOn = ~brAux_ff;
            nxt_auxOn = brAux_ff;
            nxt_state = SWC_S_TX;
          end
        end
      end
      SWC_S_TX: begin
        txEn = 1'b1;
        txBit = shift_ff[0];
        if (bitEvt) begin
          nxt_shift = {1'b1, shift_ff[15:1]};
          nxt_bitCnt = bitCnt_ff + 7'h01;
          if (bitCnt_ff[3:0] == lastBit_ff) begin
            nxt_bitCnt = 7'h00;
            nxt_state = SWC_S_DONE;
          end
        end
      end
      default: ;
    endcase
    if (rstEvt) begin
      nxt_state = SWC_S_ROMCMD;
      nxt_bitCnt = 7'h00;
      nxt_mainOe = 1'b0;
      nxt_auxOe = 1'b0;
    end
    nxt_evMain = (evMain_ff & ~clrEv) |
      (~mainOn_ff & ~mainOe_ff & mainPrev_ff & ~mainS2_ff);
    nxt_evAux = (evAux_ff & ~clrEv) | (~auxOn_ff & ~auxOe_ff & auxPrev_ff & ~auxS2_ff);
    nxt_ctrlOe = nxt_mode ? nxt_data : (nxt_sel ? nxt_auxOn : nxt_mainOn);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= SWC_S_IDLE;
      shift_ff <= 16'h0000;
      bitCnt_ff <= 7'h00;
      lastBit_ff <= 4'h7;
      brCnt_ff <= 16'h0000;
      brAux_ff <= 1'b0;
      mainOn_ff <= 1'b0;
      auxOn_ff <= 1'b0;
      mode_ff <= 1'b0;
      sel_ff <= 1'b0;
      data_ff <= 1'b0;
      evMain_ff <= 1'b0;
      evAux_ff <= 1'b0;
      mainOe_ff <= 1'b0;
      auxOe_ff <= 1'b0;
      ctrlOe_ff <= 1'b0;
      mainS1_ff <= 1'b1;
      mainS2_ff <= 1'b1;
      mainPrev_ff <= 1'b1;
      auxS1_ff <= 1'b1;
      auxS2_ff <= 1'b1;
      auxPrev_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      bitCnt_ff <= nxt_bitCnt;
      lastBit_ff <= nxt_lastBit;
      brCnt_ff <= nxt_brCnt;
      brAux_ff <= nxt_brAux;
      mainOn_ff <= nxt_mainOn;
      auxOn_ff <= nxt_auxOn;
      mode_ff <= nxt_mode;
      sel_ff <= nxt_sel;
      data_ff <= nxt_data;
      evMain_ff <= nxt_evMain;
      evAux_ff <= nxt_evAux;
      mainOe_ff <= nxt_mainOe;
      auxOe_ff <= nxt_auxOe;
      ctrlOe_ff <= nxt_ctrlOe;
      mainS1_ff <= mainIn;
      mainS2_ff <= mainS1_ff;
      mainPrev_ff <= mainS2_ff;
      auxS1_ff <= auxIn;
      auxS2_ff <= auxS1_ff;
      auxPrev_ff <= auxS2_ff;
    end
  end

  assign mainOe = mainOe_ff;
  assign auxOe = auxOe_ff;
  assign mainOn = mainOn_ff;
  assign auxOn = auxOn_ff;
  assign ctrlOe = ctrlOe_ff;
endmodule

// ### swc_regs.svh
// command codes, id layout and link timing of the coupler link
`ifndef SWC_REGS_SVH
`define SWC_REGS_SVH
`define SWC_CLK_NS 10
`define SWC_CYC(ns) (((ns) + `SWC_CLK_NS - 1) / `SWC_CLK_NS)
`define SWC_SLOT_NS 61350
`define SWC_LOW1_NS 6000
`define SWC_LOW0_NS 54000
`define SWC_MSAMP_NS 15000
`define SWC_DSAMP_NS 30000
`define SWC_RST_NS 480000
`define SWC_RST_MIN_NS 400000
`define SWC_PWAIT_NS 30000
`define SWC_PLOW_NS 120000
`define SWC_PSAMP_NS 70000
`define SWC_CNT_MAX 65535
`define SWC_CRC_POLY 8'h8C
`define SWC_ID_SER_LSB 8
`define SWC_ID_CRC_LSB 56
`define SWC_ROM_READ 8'h33
`define SWC_ROM_MATCH 8'h55
`define SWC_ROM_SEARCH 8'hF0
`define SWC_ROM_SKIP 8'hCC
`define SWC_ROM_CSRCH 8'hEC
`define SWC_FN_STATUS 8'h5A
`define SWC_FN_ALLOFF 8'h66
`define SWC_FN_DIRMAIN 8'hA5
`define SWC_FN_SMARTMAIN 8'hCC
`define SWC_FN_SMARTAUX 8'h33
`define SWC_SC_DATA 7
`define SWC_SC_SEL 6
`define SWC_SC_MODE 5
`define SWC_SC_WRHI 4
`define SWC_SC_WRLO 3
`endif

// ### swc_pkg.sv
// types and CRC helpers shared by both ends of the link
package swc_pkg;
  `include "swc_regs.svh"

  typedef enum {SWC_S_IDLE, SWC_S_ROMCMD, SWC_S_READROM, SWC_S_MATCH, SWC_S_SRCH_ID,
    SWC_S_SRCH_CMP, SWC_S_SRCH_DIR, SWC_S_FUNC, SWC_S_STATCTL, SWC_S_BRLOW,
    SWC_S_BRWAIT, SWC_S_TX, SWC_S_DONE} swc_dev_state_t;

  typedef enum {SWC_M_IDLE, SWC_M_RLOW, SWC_M_RWAIT, SWC_M_SLOT} swc_mst_state_t;

  typedef enum logic [2:0] {SWC_K_RESET, SWC_K_WBYTE, SWC_K_RBYTE, SWC_K_WBIT, SWC_K_RBIT,
    SWC_K_CRCCLR} swc_kind_t;

  function automatic logic [7:0] swc_crc_step(input logic [7:0] crc, input logic b);
    logic fb;
    fb = crc[0] ^ b;
    swc_crc_step = (crc >> 1) ^ (fb ? `SWC_CRC_POLY : 8'h00);
  endfunction

  function automatic logic [7:0] swc_rom_crc(input logic [55:0] val);
    logic [7:0] crc;
    crc = 8'h00;
    for (int i = 0; i < 56; i++) begin
      crc = swc_crc_step(crc, val[i]);
    end
    swc_rom_crc = crc;
  endfunction
endpackage

// ### swc_link_if.sv
// shared open-drain data line between master and coupler
`timescale 1ns/1ps
interface swc_link_if;
  logic mstOe;
  logic devOe;
  logic dq;
  assign dq = ~(mstOe | devOe);
  modport mst(output mstOe, input dq);
  modport dev(output devOe, input dq);
endinterface

// ### swc_master_end.sv
// master end: reset pulses and bit slots on the link
`timescale 1ns/1ps
`include "swc_regs.svh"
module swc_master_end
  import swc_pkg::*;
#(
  parameter int RST_CYC = `SWC_CYC(`SWC_RST_NS),
  parameter int SLOT_CYC = `SWC_CYC(`SWC_SLOT_NS),
  parameter int LOW0_CYC = `SWC_CYC(`SWC_LOW0_NS),
  parameter int PSAMP_CYC = `SWC_CYC(`SWC_PSAMP_NS),
  parameter int LOW1_CYC = `SWC_CYC(`SWC_LOW1_NS),
  parameter int MSAMP_CYC = `SWC_CYC(`SWC_MSAMP_NS)
) (
  input wire logic clk,
  input wire logic nrst,
  swc_link_if.mst link,
  input wire logic cmdValid,
  input wire swc_kind_t cmdKind,
  input wire logic [7:0] cmdData,
  output logic cmdReady,
  output logic respValid,
  output logic [7:0] respData,
  output logic [7:0] crcVal
);
  localparam logic [15:0] RST_C = 16'(RST_CYC - 1);
  localparam logic [15:0] SLOT_C = 16'(SLOT_CYC - 1);
  localparam logic [15:0] LOW0_C = 16'(LOW0_CYC - 1);
  localparam logic [15:0] LOW1_C = 16'(LOW1_CYC - 1);
  localparam logic [15:0] MSAMP_C = 16'(MSAMP_CYC);
  localparam logic [15:0] PSAMP_C = 16'(PSAMP_CYC);

  if (RST_CYC < 2 || RST_CYC > `SWC_CNT_MAX || SLOT_CYC > `SWC_CNT_MAX ||
      LOW1_CYC < 1 || LOW1_CYC >= MSAMP_CYC ||
      LOW0_CYC <= MSAMP_CYC || LOW0_CYC >= SLOT_CYC || PSAMP_CYC >= RST_CYC) begin : g_chk
    $error("swc_master_end: timing count out of range");
  end

  swc_mst_state_t state_ff, nxt_state;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [7:0] shift_ff, nxt_shift, respData_ff, nxt_respData, crc_ff, nxt_crc;
  logic [2:0] bitIdx_ff, nxt_bitIdx, lastIdx_ff, nxt_lastIdx;
  logic curBit_ff, nxt_curBit, mstOe_ff, nxt_mstOe, ready_ff, nxt_ready;
  logic respValid_ff, nxt_respValid, dqS1_ff, dqS2_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 16'h0001;
    nxt_shift = shift_ff;
    nxt_respData = respData_ff;
    nxt_crc = crc_ff;
    nxt_bitIdx = bitIdx_ff;
    nxt_lastIdx = lastIdx_ff;
    nxt_curBit = curBit_ff;
    nxt_mstOe = mstOe_ff;
    nxt_ready = ready_ff;
    nxt_respValid = 1'b0;
    case (state_ff)
      SWC_M_IDLE: begin
        nxt_cnt = 16'h0000;
        if (cmdValid && ready_ff) begin
          nxt_ready = 1'b0;
          nxt_mstOe = 1'b1;
          nxt_bitIdx = 3'h0;
          nxt_lastIdx = 3'h7;
          nxt_state = SWC_M_SLOT;
          case (cmdKind)
            SWC_K_RESET: nxt_state = SWC_M_RLOW;
            SWC_K_WBYTE: nxt_shift = cmdData;
            SWC_K_RBYTE: nxt_shift = 8'hFF;
            SWC_K_WBIT: begin
              nxt_shift = {7'h7F, cmdData[0]};
              nxt_lastIdx = 3'h0;
            end
            SWC_K_RBIT: begin
              nxt_shift = 8'hFF;
              nxt_lastIdx = 3'h0;
            end
            default: begin
              nxt_crc = 8'h00;
              nxt_mstOe = 1'b0;
              nxt_ready = 1'b1;
              nxt_respValid = 1'b1;
              nxt_state = SWC_M_IDLE;
            end
          endcase
          nxt_curBit = nxt_shift[0];
        end
      end
      SWC_M_RLOW: begin
        if (cnt_ff == RST_C) begin
          nxt_cnt = 16'h0000;
          nxt_mstOe = 1'b0;
          nxt_state = SWC_M_RWAIT;
        end
      end
      SWC_M_RWAIT: begin
        if (cnt_ff == PSAMP_C) begin
          nxt_respData = {7'h00, ~dqS2_ff};
        end
        if (cnt_ff == RST_C) begin
          nxt_ready = 1'b1;
          nxt_respValid = 1'b1;
          nxt_state = SWC_M_IDLE;
        end
      end
      SWC_M_SLOT: begin
        if (cnt_ff == (curBit_ff ? LOW1_C : LOW0_C)) begin
          nxt_mstOe = 1'b0;
        end
        if (cnt_ff == MSAMP_C) begin
          nxt_shift = {dqS2_ff, shift_ff[7:1]};
          nxt_crc = swc_crc_step(crc_ff, dqS2_ff);
        end
        if (cnt_ff == SLOT_C) begin
          nxt_cnt = 16'h0000;
          if (bitIdx_ff == lastIdx_ff) begin
            nxt_respData = (lastIdx_ff == 3'h0) ? {7'h00, shift_ff[7]} : shift_ff;
            nxt_ready = 1'b1;
            nxt_respValid = 1'b1;
            nxt_state = SWC_M_IDLE;
          end else begin
            nxt_bitIdx = bitIdx_ff + 3'h1;
            nxt_curBit = shift_ff[0];
            nxt_mstOe = 1'b1;
          end
        end
      end
      default: nxt_state = SWC_M_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= SWC_M_IDLE;
      cnt_ff <= 16'h0000;
      shift_ff <= 8'h00;
      respData_ff <= 8'h00;
      crc_ff <= 8'h00;
      bitIdx_ff <= 3'h0;
      lastIdx_ff <= 3'h7;
      curBit_ff <= 1'b1;
      mstOe_ff <= 1'b0;
      ready_ff <= 1'b1;
      respValid_ff <= 1'b0;
      dqS1_ff <= 1'b1;
      dqS2_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      respData_ff <= nxt_respData;
      crc_ff <= nxt_crc;
      bitIdx_ff <= nxt_bitIdx;
      lastIdx_ff <= nxt_lastIdx;
      curBit_ff <= nxt_curBit;
      mstOe_ff <= nxt_mstOe;
      ready_ff <= nxt_ready;
      respValid_ff <= nxt_respValid;
      dqS1_ff <= link.dq;
      dqS2_ff <= dqS1_ff;
    end
  end

  assign link.mstOe = mstOe_ff;
  assign cmdReady = ready_ff;
  assign respValid = respValid_ff;
  assign respData = respData_ff;
  assign crcVal = crc_ff;
endmodule

// ### swc_link_checker.sv
// link timing checker for the master end and coupler on the shared line
`timescale 1ns/1ps
module swc_link_checker #(
  parameter int RST_CYC = 4000,
  parameter int SLOT_CYC = 3100,
  parameter int LOW0_CYC = 3050,
  parameter int PLOW_CYC = 120,
  parameter int LOW1_CYC = 600,
  parameter int PWAIT_CYC = 3000,
  parameter int SAMP_CYC = 3000
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic mstOe,
  input wire logic devOe,
  input wire logic dq
);
  logic [15:0] loCnt_ff;
  logic [15:0] nxt_loCnt;
  logic [15:0] hiCnt_ff;
  logic [15:0] nxt_hiCnt;
  logic [15:0] devCnt_ff;
  logic [15:0] nxt_devCnt;
  logic presWait_ff;
  logic nxt_presWait;

  // run lengths of master low, master released and coupler drive; presence owed
  always_comb begin
    nxt_presWait = (presWait_ff | (!mstOe && loCnt_ff == 16'(RST_CYC))) & !devOe;
    nxt_loCnt = mstOe ? loCnt_ff + 16'h0001 : 16'h0000;
    nxt_hiCnt = mstOe ? 16'h0000 : hiCnt_ff + {15'h0000, hiCnt_ff != 16'hFFFF};
    nxt_devCnt = devOe ? devCnt_ff + 16'h0001 : 16'h0000;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      loCnt_ff <= 16'h0000;
      hiCnt_ff <= 16'hFFFF;
      devCnt_ff <= 16'h0000;
      presWait_ff <= 1'b0;
    end else begin
      presWait_ff <= nxt_presWait;
      loCnt_ff <= nxt_loCnt;
      hiCnt_ff <= nxt_hiCnt;
      devCnt_ff <= nxt_devCnt;
    end
  end

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  presence_start_a: assert property ($rose(devOe) && !mstOe |->
    hiCnt_ff >= PWAIT_CYC - 5 && hiCnt_ff <= PWAIT_CYC + 10)
    else $error("presence began at the wrong time");
  zero_drive_a: assert property ($rose(devOe) && mstOe |-> loCnt_ff inside {[1:8]})
    else $error("zero bit drive began late");
  drive_len_a: assert property ($fell(devOe) |-> devCnt_ff == PLOW_CYC ||
    (devCnt_ff >= SAMP_CYC - 10 && devCnt_ff <= SAMP_CYC + 5))
    else $error("coupler drive had a wrong length");
  master_low_a: assert property ($fell(mstOe) |->
    loCnt_ff inside {LOW1_CYC, LOW0_CYC, RST_CYC})
    else $error("master low had a wrong length");
  slot_start_a: assert property ($rose(mstOe) |->
    $past(dq) && hiCnt_ff >= SLOT_CYC - LOW0_CYC - 1)
    else $error("slot started too soon");
  reset_quiet_a: assert property (mstOe && loCnt_ff > SLOT_CYC |-> !devOe)
    else $error("coupler drove during a reset pulse");
  presence_due_a: assert property (presWait_ff |->
    !mstOe && hiCnt_ff <= PWAIT_CYC + 10)
    else $error("no presence after reset");
  idle_quiet_a: assert property (devOe |->
    mstOe || hiCnt_ff <= PWAIT_CYC + PLOW_CYC + 20)
    else $error("coupler drove an idle line");
endmodule

// ### tb_top.sv
// self-checking bench: master end and coupler joined over the link
`timescale 1ns/1ps
`include "swc_regs.svh"
module tb_top;
  import swc_pkg::*;
  localparam logic [7:0] TYPE = 8'h5B; // arbitrary value
  localparam logic [47:0] SER = 48'h0012_3456_789A; // arbitrary value
  // shortened link timing so the whole run stays short
  localparam int M_RST = 400;
  localparam int M_SLOT = 200;
  localparam int M_LOW0 = 150;
  localparam int M_LOW1 = 20;
  localparam int M_MSAMP = 50;
  localparam int M_PSAMP = 160;
  localparam int D_RSTMIN = 300;
  localparam int D_BRST = 200;
  localparam int D_PLOW = 120;
  localparam int D_PWAIT = 100;
  localparam int D_SAMP = 100;
  logic clk, nrst, cmdValid, cmdReady, respValid;
  swc_kind_t cmdKind;
  logic [7:0] cmdData, respData, crcVal, r;
  logic mainOe, auxOe, mainOn, auxOn, ctrlOe, mainPull, auxPull, sawOe;
  logic [63:0] id;
  int n_mismatch, n_tests;
  // branch wire: coupler pulse or an arriving device pulls it low
  wire logic mainIn = ~(mainOe | mainPull);
  wire logic auxIn = ~(auxOe | auxPull);

  swc_link_if swc_link_if_inst();
  swc_master_end #(.RST_CYC(M_RST), .SLOT_CYC(M_SLOT), .LOW0_CYC(M_LOW0), .PSAMP_CYC(M_PSAMP),
    .LOW1_CYC(M_LOW1), .MSAMP_CYC(M_MSAMP))
    swc_master_end_inst (.clk(clk), .nrst(nrst), .link(swc_link_if_inst.mst),
    .cmdValid(cmdValid), .cmdKind(cmdKind), .cmdData(cmdData), .cmdReady(cmdReady),
    .respValid(respValid), .respData(respData), .crcVal(crcVal));
  swc_coupler_dev #(.TYPE_CODE(TYPE), .SERIAL(SER), .RST_MIN_CYC(D_RSTMIN), .BRST_CYC(D_BRST),
    .PLOW_CYC(D_PLOW), .PWAIT_CYC(D_PWAIT), .SAMP_CYC(D_SAMP))
    swc_coupler_dev_inst (.clk(clk), .nrst(nrst), .link(swc_link_if_inst.dev),
    .mainIn(mainIn), .auxIn(auxIn), .mainOe(mainOe), .auxOe(auxOe), .mainOn(mainOn),
    .auxOn(auxOn), .ctrlOe(ctrlOe));
  swc_link_checker #(.RST_CYC(M_RST), .SLOT_CYC(M_SLOT), .LOW0_CYC(M_LOW0), .PLOW_CYC(D_PLOW),
    .LOW1_CYC(M_LOW1), .PWAIT_CYC(D_PWAIT), .SAMP_CYC(D_SAMP))
    swc_link_checker_inst (.clk(clk), .nrst(nrst), .mstOe(swc_link_if_inst.mstOe),
    .devOe(swc_link_if_inst.devOe), .dq(swc_link_if_inst.dq));

  function automatic logic [7:0] crc8(input logic [55:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      c = (c >> 1) ^ ((c[0] ^ v[i]) ? 8'h8C : 8'h00);
    end
    return c;
  endfunction

  task automatic final_report();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // one request, held for one clock, then wait for the answer pulse
  task automatic op(input swc_kind_t k, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdKind <= k;
    cmdData <= d;
    @(posedge clk);
    cmdValid <= 1'b0;
    @(negedge clk);
    chk("busy", {7'h00, cmdReady}, {7'h00, k == SWC_K_CRCCLR});
    while (respValid !== 1'b1 && n < 30000) begin
      @(negedge clk);
      n++;
    end
    chk("answer", {7'h00, respValid}, 8'h01);
    chk("ready", {7'h00, cmdReady}, 8'h01);
    r = respData;
  endtask

  task automatic start(input logic [7:0] c);
    op(SWC_K_RESET, 8'h00);
    chk("presence", r, 8'h01);
    op(SWC_K_WBYTE, c);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #850_000;
    n_mismatch++;
    final_report();
  end

  initial begin
    nrst = 1'b0;
    cmdValid = 1'b0;
    cmdKind = SWC_K_RESET;
    cmdData = 8'h00;
    mainPull = 1'b0;
    auxPull = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    id = {crc8({SER, TYPE}), SER, TYPE};
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk("branches off", {6'h00, auxOn, mainOn}, 8'h00);
    start(`SWC_ROM_READ);
    op(SWC_K_CRCCLR, 8'h00);
    for (int i = 0; i < 8; i++) begin
      op(SWC_K_RBYTE, 8'hFF);
      chk("id byte", r, id[8*i +: 8]);
    end
    chk("id crc", crcVal, 8'h00);
    // function code where a ROM command belongs
    start(`SWC_FN_ALLOFF);
    op(SWC_K_RBYTE, 8'hFF);
    chk("ignored fn", r, 8'hFF);
    @(posedge clk);
    auxPull <= 1'b1;
    repeat (10) @(posedge clk);
    auxPull <= 1'b0;
    start(`SWC_ROM_CSRCH);
    op(SWC_K_RBIT, 8'h00);
    chk("srch bit", r, {7'h00, TYPE[0]});
    op(SWC_K_RBIT, 8'h00);
    chk("srch cmp", r, {7'h00, ~TYPE[0]});
    start(`SWC_ROM_SKIP);
    op(SWC_K_WBYTE, `SWC_FN_STATUS);
    op(SWC_K_WBYTE, 8'hA0);
    op(SWC_K_RBYTE, 8'hFF);
    chk("status", r, 8'hEF);
    chk("ctrlOe", {7'h00, ctrlOe}, 8'h01);
    for (int b = 0; b < 2; b++) begin
      start(`SWC_ROM_SKIP);
      op(SWC_K_WBYTE, b ? `SWC_FN_SMARTAUX : `SWC_FN_SMARTMAIN);
      sawOe = 1'b0;
      repeat (450) begin
        @(negedge clk);
        if ((b ? auxOe && !auxOn : mainOe && !mainOn) === 1'b1) sawOe = 1'b1;
      end
      chk("pulse first", {7'h00, sawOe}, 8'h01);
      op(SWC_K_RBYTE, 8'hFF);
      chk("echo", r, b ? `SWC_FN_SMARTAUX : `SWC_FN_SMARTMAIN);
      chk("branch on", {6'h00, auxOn, mainOn}, b ? 8'h02 : 8'h01);
      op(SWC_K_RBYTE, 8'hFF);
      chk("deselected", r, 8'hFF);
    end
    // addressed by full id, then main switched on directly
    start(`SWC_ROM_MATCH);
    for (int i = 0; i < 8; i++) begin
      op(SWC_K_WBYTE, id[8*i +: 8]);
    end
    op(SWC_K_WBYTE, `SWC_FN_DIRMAIN);
    op(SWC_K_RBYTE, 8'hFF);
    chk("main echo", r, `SWC_FN_DIRMAIN);
    chk("main on", {6'h00, auxOn, mainOn}, 8'h01);
    start(`SWC_ROM_SKIP);
    op(SWC_K_WBYTE, `SWC_FN_ALLOFF);
    op(SWC_K_RBYTE, 8'hFF);
    chk("off echo", r, `SWC_FN_ALLOFF);
    chk("all off", {6'h00, auxOn, mainOn}, 8'h00);
    start(`SWC_ROM_CSRCH);
    op(SWC_K_RBIT, 8'h00);
    chk("no srch", r, 8'h01);
    final_report();
  end
endmodule
